// [src/ustw_top.sv]
// Purpose: shift-register serial unit with two-wire slave clock control
// Assumes: AXI4-Lite register access, scl/sda as open-drain pin triples
// Notes: start detection is sampled on aclk, not truly clockless
//
// Overview of operation
// - both ends shift data out on falling scl
// - shifting clock edges also advance counter, except external clock with strobe select set
// - sda driven low when bit 7 or port zero
// - sda falling while scl high sets start flag
// - start holds scl low until start flag cleared
// - slave samples sda on rising scl edge
// - overflow after eight bits holds scl low in the hold variant of two-wire mode only
// - sda delayed 50 to 300 ns for detection
// - start detector works only in two-wire mode
// - start detection independent of processor clock activity
// - external clock counts both scl edges unless strobe select set
// - counter at F overflows on next event
// - software write beats simultaneous shift
// - shift source chosen by clock source select
// - inputs still clock unit with no wire mode
// - output pin follows bit 7 through latch in three-wire mode, sda does in two-wire mode
// - latch open first half-cycle, always when internal
// - completed transfer copied to receive buffer
// - outside two-wire, scl edges set start flag when external clock and strobe select clear
// - start flag write-one-clear, gated interrupt request
// - overflow flag sets on wrap, clears scl hold
// - stop flag set on stop, no interrupt
//
// Implementation choices: the AXI4-Lite register port and the register addresses.
module ustw_top
	import ustw_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	output logic data_out_pin,
	input wire logic timer_match,
	input wire logic global_int_enable,
	output logic start_irq,
	output logic ovf_irq
);

	function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
		return (a == ADDR_SHIFT) || (a == ADDR_RXBUF) || (a == ADDR_STATUS) ||
			(a == ADDR_CTRL) || (a == ADDR_PINS);
	endfunction

	ustw_ctrl_type ctrl_q;
	ustw_ctrl_type ctrl_now;
	ustw_pins_type pins_q;
	ustw_line_ev_type ev;
	logic [7:0] shift_q, shift_d, rxbuf_q;
	logic [3:0] cnt_q;
	logic latch_q;
	logic start_q, ovf_q, stop_q, start_hold_q;
	logic scl_s, sda_s;
	logic two_wire, ext_clk, latch_open, collision, ovf_hold;
	logic shift_evt, cnt_evt, ovf_evt, edge_evt;
	logic wr_en, wr_sel, wr_shift, wr_status, wr_ctrl, wr_pins;
	logic sw_clk, sw_toggle;
	logic [7:0] wbyte;
	logic [7:0] rd_byte;

	ustw_sync u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in({scl_in, sda_in}),
		.sync_out({scl_s, sda_s})
	);

	ustw_line_detect u_detect (
		.aclk(aclk),
		.aresetn(aresetn),
		.enable(two_wire),
		.scl_s(scl_s),
		.sda_s(sda_s),
		.ev(ev)
	);

	// write channel: both address and data must be offered before taking them
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
			s_axi_wready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
		end
	end

	assign wr_en = s_axi_awready & s_axi_awvalid & s_axi_wvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (wr_en) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= addr_mapped(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// registers are one byte wide, only lane 0 carries them
	assign wr_sel = wr_en & s_axi_wstrb[0];
	assign wbyte = s_axi_wdata[7:0];
	assign wr_shift = wr_sel & (s_axi_awaddr == ADDR_SHIFT);
	assign wr_status = wr_sel & (s_axi_awaddr == ADDR_STATUS);
	assign wr_ctrl = wr_sel & (s_axi_awaddr == ADDR_CTRL);
	assign wr_pins = wr_sel & (s_axi_awaddr == ADDR_PINS);

	// read channel
	always_comb begin
		case (s_axi_araddr)
			ADDR_SHIFT: rd_byte = shift_q;
			ADDR_RXBUF: rd_byte = rxbuf_q;
			ADDR_STATUS: rd_byte = {start_q, ovf_q, stop_q, collision, cnt_q};
			ADDR_CTRL: rd_byte = ctrl_q;
			ADDR_PINS: rd_byte = {4'h0, pins_q};
			default: rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
		end else begin
			s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arready & s_axi_arvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h00_0000, rd_byte};
			s_axi_rresp <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// control and pin registers; the toggle strobe bit 0 is not stored
	assign sw_clk = wr_ctrl & wbyte[1];
	assign sw_toggle = wr_ctrl & wbyte[0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_q <= {wbyte[7:1], 1'b0};
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pins_q <= PINS_RST;
		end else if (wr_pins) begin
			pins_q <= wbyte[3:0];
		end else if (sw_toggle) begin
			pins_q.scl_port <= ~pins_q.scl_port;
		end
	end

	assign two_wire = ctrl_q.wire_mode_select[1];
	assign ext_clk = ctrl_q.clock_source_select[1];
	assign edge_evt = ev.scl_rise | ev.scl_fall;
	// a strobe written with a new source must act under that source, not the old one
	assign ctrl_now = wr_ctrl ? ustw_ctrl_type'({wbyte[7:1], 1'b0}) : ctrl_q;

	// clock source choice; wire mode does not gate the inputs
	always_comb begin
		case (ctrl_now.clock_source_select)
			CS_SOFT: shift_evt = sw_clk;
			CS_TIMER: shift_evt = timer_match;
			CS_EXT_POS: shift_evt = ev.scl_rise;
			CS_EXT_NEG: shift_evt = ev.scl_fall;
			default: shift_evt = 1'b0;
		endcase
		if (!ctrl_now.clock_source_select[1]) begin
			cnt_evt = shift_evt;
		end else if (ctrl_now.software_clock_strobe_select) begin
			cnt_evt = sw_toggle;
		end else begin
			cnt_evt = edge_evt;
		end
	end

	// shift register; a software write wins over a shift in the same cycle
	always_comb begin
		if (wr_shift) begin
			shift_d = wbyte;
		end else if (shift_evt) begin
			shift_d = {shift_q[6:0], sda_s};
		end else begin
			shift_d = shift_q;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shift_q <= SHIFT_RST;
		end else begin
			shift_q <= shift_d;
		end
	end

	// edge counter; a software load wins over a count
	assign ovf_evt = cnt_evt & ~wr_status & (cnt_q == CNT_MAX);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= CNT_RST;
		end else if (wr_status) begin
			cnt_q <= wbyte[STS_CNT_HI:0];
		end else if (cnt_evt) begin
			cnt_q <= cnt_q + 4'h1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rxbuf_q <= RXBUF_RST;
		end else if (ovf_evt) begin
			rxbuf_q <= shift_d;
		end
	end

	// flags: hardware set wins over a write-one clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			start_q <= 1'b0;
		end else if (ev.start_det ||
			(!two_wire && ext_clk && !ctrl_q.software_clock_strobe_select && edge_evt)) begin
			start_q <= 1'b1;
		end else if (wr_status && wbyte[STS_START]) begin
			start_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ovf_q <= 1'b0;
		end else if (ovf_evt) begin
			ovf_q <= 1'b1;
		end else if (wr_status && wbyte[STS_OVF]) begin
			ovf_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stop_q <= 1'b0;
		end else if (ev.stop_det) begin
			stop_q <= 1'b1;
		end else if (wr_status && wbyte[STS_STOP]) begin
			stop_q <= 1'b0;
		end
	end

	// scl hold after start only begins once the master has pulled scl low
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			start_hold_q <= 1'b0;
		end else if (two_wire && start_q && ev.scl_fall) begin
			start_hold_q <= 1'b1;
		end else if (!start_q || !two_wire) begin
			start_hold_q <= 1'b0;
		end
	end

	// only the hold variant of two-wire mode stretches after overflow
	assign ovf_hold = ovf_q & (ctrl_q.wire_mode_select == WM_TWO_HOLD);

	// output latch keeps sample and drive on opposite scl edges
	always_comb begin
		if (!ext_clk) begin
			latch_open = 1'b1;
		end else if (ctrl_q.clock_source_select == CS_EXT_NEG) begin
			latch_open = ev.scl_level;
		end else begin
			latch_open = ~ev.scl_level;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			latch_q <= 1'b0;
		end else if (latch_open) begin
			latch_q <= shift_d[7];
		end
	end

	assign collision = two_wire & (shift_q[7] != sda_s);

	// pins: open-drain in two-wire mode, plain port otherwise
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sda_out <= 1'b0;
			sda_oe <= 1'b0;
			scl_out <= 1'b0;
			scl_oe <= 1'b0;
			data_out_pin <= 1'b0;
		end else if (two_wire) begin
			sda_out <= 1'b0;
			sda_oe <= pins_q.sda_dir & (~latch_q | ~pins_q.sda_port);
			scl_out <= 1'b0;
			scl_oe <= (pins_q.scl_dir & ~pins_q.scl_port) | start_hold_q | ovf_hold;
			data_out_pin <= 1'b0;
		end else begin
			sda_out <= pins_q.sda_port;
			sda_oe <= pins_q.sda_dir;
			scl_out <= pins_q.scl_port;
			scl_oe <= pins_q.scl_dir;
			data_out_pin <= (ctrl_q.wire_mode_select == WM_THREE) ? latch_q : 1'b0;
		end
	end

	// interrupt requests; the stop flag never requests one
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			start_irq <= 1'b0;
			ovf_irq <= 1'b0;
		end else begin
			start_irq <= start_q & ctrl_q.start_interrupt_enable & global_int_enable;
			ovf_irq <= ovf_q & ctrl_q.overflow_interrupt_enable & global_int_enable;
		end
	end

endmodule

// [src/ustw_pkg.sv]
// Purpose: shared constants and types of the two-wire serial unit
// Assumes: AXI4-Lite register access with 8-bit registers in the low byte lane
// Notes: byte addresses are word aligned
package ustw_pkg;

	localparam int ADDR_W = 8;

	// register byte addresses
	localparam logic [7:0] ADDR_SHIFT = 8'h00;
	localparam logic [7:0] ADDR_RXBUF = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_CTRL = 8'h0c;
	localparam logic [7:0] ADDR_PINS = 8'h10;

	// status field positions
	localparam int STS_START = 7;
	localparam int STS_OVF = 6;
	localparam int STS_STOP = 5;
	localparam int STS_COLL = 4;
	localparam int STS_CNT_HI = 3;

	// reset values and the counter maximum
	localparam logic [7:0] SHIFT_RST = 8'h00;
	localparam logic [7:0] RXBUF_RST = 8'h00;
	localparam logic [3:0] CNT_RST = 4'h0;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [3:0] PINS_RST = 4'h0;
	localparam logic [3:0] CNT_MAX = 4'hf;

	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// sda delay of the start detector
	localparam int CLK_PERIOD_NS = 5;
	localparam int SDA_DELAY_NS = 50;
	localparam int SDA_DELAY_CYC = (SDA_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		WM_NONE = 2'b00,
		WM_THREE = 2'b01,
		WM_TWO = 2'b10,
		WM_TWO_HOLD = 2'b11
	} ustw_wire_mode_type;

	typedef enum logic [1:0] {
		CS_SOFT = 2'b00,
		CS_TIMER = 2'b01,
		CS_EXT_POS = 2'b10,
		CS_EXT_NEG = 2'b11
	} ustw_clock_source_type;

	// control register, bit 7 down to bit 0
	typedef struct packed {
		logic start_interrupt_enable;
		logic overflow_interrupt_enable;
		ustw_wire_mode_type wire_mode_select;
		ustw_clock_source_type clock_source_select;
		logic software_clock_strobe_select;
		logic clock_pin_toggle_strobe;
	} ustw_ctrl_type;

	// pin register, bit 3 down to bit 0
	typedef struct packed {
		logic scl_dir;
		logic sda_dir;
		logic scl_port;
		logic sda_port;
	} ustw_pins_type;

	// events of the line detector
	typedef struct packed {
		logic scl_level;
		logic scl_rise;
		logic scl_fall;
		logic start_det;
		logic stop_det;
	} ustw_line_ev_type;

endpackage

// [src/ustw_sync.sv]
// Purpose: two-flop synchroniser for the scl and sda pin inputs
// Assumes: inputs are asynchronous to aclk
// Notes: first stage feeds only the second stage
module ustw_sync (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [1:0] async_in,
	output logic [1:0] sync_out
);

	logic [1:0] meta_q;

	genvar i;
	generate
		for (i = 0; i < 2; i++) begin : g_bit
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					meta_q[i] <= 1'b1;
					sync_out[i] <= 1'b1;
				end else begin
					meta_q[i] <= async_in[i];
					sync_out[i] <= meta_q[i];
				end
			end
		end
	endgenerate

endmodule

// [src/ustw_line_detect.sv]
// Purpose: scl edge finder and start/stop detector on the synchronised lines
// Assumes: scl_s and sda_s are already synchronised to aclk
// Notes: sda passes a delay line so scl is settled when sda moves
module ustw_line_detect
	import ustw_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic enable,
	input wire logic scl_s,
	input wire logic sda_s,
	output ustw_line_ev_type ev
);

	logic [SDA_DELAY_CYC-1:0] sda_line_q;
	logic sda_dly_prev_q;
	logic scl_prev_q;
	logic sda_dly;

	assign sda_dly = sda_line_q[SDA_DELAY_CYC-1];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sda_line_q <= '1;
			sda_dly_prev_q <= 1'b1;
			scl_prev_q <= 1'b1;
		end else begin
			sda_line_q <= {sda_line_q[SDA_DELAY_CYC-2:0], sda_s};
			sda_dly_prev_q <= sda_dly;
			scl_prev_q <= scl_s;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ev <= '0;
			ev.scl_level <= 1'b1;
		end else begin
			ev.scl_level <= scl_s;
			ev.scl_rise <= scl_s & ~scl_prev_q;
			ev.scl_fall <= ~scl_s & scl_prev_q;
			ev.start_det <= enable & scl_s & sda_dly_prev_q & ~sda_dly;
			ev.stop_det <= enable & scl_s & ~sda_dly_prev_q & sda_dly;
		end
	end

endmodule

// [dv/ustw_checker.sv]
// Purpose: port-level checks of the two-wire serial unit
// Assumes: master holds each write address until awready
// Notes: wire mode is tracked from control register writes
module ustw_checker
	import ustw_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic scl_out,
	input wire logic scl_oe,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic global_int_enable,
	input wire logic start_irq,
	input wire logic ovf_irq
);
	logic [7:0] ctrl_q;
	logic [3:0] since_q;
	logic start_en;
	logic ovf_en;
	assign start_en = ctrl_q[7];
	assign ovf_en = ctrl_q[6];
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	always_ff @(posedge aclk) begin
		if (!aresetn)
			ctrl_q <= CTRL_RST;
		else if (s_axi_awready && s_axi_awaddr == ADDR_CTRL && s_axi_wstrb[0])
			ctrl_q <= s_axi_wdata[7:0];
	end
	// saturating age of the last status write, a hold may only end soon after one
	always_ff @(posedge aclk) begin
		if (!aresetn || (s_axi_awready && s_axi_awaddr == ADDR_STATUS))
			since_q <= 4'h0;
		else if (since_q != 4'hf)
			since_q <= since_q + 4'h1;
	end
	sequence wr_taken;
		s_axi_awready && s_axi_wready;
	endsequence
	sequence rd_refused;
		s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
	endsequence
	chk_scl_open_drain: assert property (ctrl_q[5] && scl_oe |-> !scl_out)
		else $error("scl driven high in two-wire mode");
	chk_sda_open_drain: assert property (ctrl_q[5] && sda_oe |-> !sda_out)
		else $error("sda driven high in two-wire mode");
	chk_hold_release: assert property (ctrl_q[5] && $fell(scl_oe) |-> since_q != 4'hf)
		else $error("scl hold ended without a status write");
	chk_irq_global: assert property (start_irq || ovf_irq |-> $past(global_int_enable))
		else $error("interrupt raised while globally disabled");
	chk_start_irq_en: assert property (start_irq |-> $past(start_en))
		else $error("start interrupt without its enable");
	chk_ovf_irq_en: assert property (ovf_irq |-> $past(ovf_en))
		else $error("overflow interrupt without its enable");
	chk_write_answer: assert property (wr_taken |=> s_axi_bvalid)
		else $error("write response missing after accept");
	chk_read_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer changed before rready");
	chk_unmapped_read: assert property (s_axi_arready && s_axi_araddr[7:5] != 3'h0 |=> rd_refused)
		else $error("unmapped read not refused");
endmodule

bind ustw_top ustw_checker chk (
	.aclk, .aresetn, .s_axi_awaddr, .s_axi_wdata, .s_axi_wstrb, .s_axi_awready,
	.s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arready, .s_axi_rdata,
	.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .scl_out, .scl_oe, .sda_out, .sda_oe,
	.global_int_enable, .start_irq, .ovf_irq
);

// [dv/ustw_master_model.sv]
// Purpose: far-side bus master that clocks bytes by hand
// Assumes: both lines have pull-ups, low pulls win
// Notes: a stretch longer than the wait bound sets stuck
module ustw_master_model (
	input wire logic scl_line,
	output logic scl_low,
	output logic sda_low,
	output logic stuck
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HALF_NS = 32;
	// sda moves this long before scl rises, longer than the slave's sda delay
	localparam int SETUP_NS = 3 * HALF_NS;
	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
		stuck = 1'b0;
	end
	task automatic release_scl();
		int i;
		scl_low = 1'b0;
		for (i = 0; i < 4000 && !scl_line; i++)
			#1;
		if (!scl_line)
			stuck = 1'b1;
	endtask
	task automatic start_cond();
		sda_low = 1'b1;
		#SETUP_NS;
		scl_low = 1'b1;
		#HALF_NS;
	endtask
	// data only moves while scl is low
	task automatic send_byte(input logic [7:0] b);
		for (int k = 7; k >= 0; k--) begin
			sda_low = !b[k];
			#SETUP_NS;
			release_scl();
			#HALF_NS;
			scl_low = 1'b1;
		end
	endtask
	task automatic stop_cond();
		sda_low = 1'b1;
		#SETUP_NS;
		release_scl();
		#HALF_NS;
		sda_low = 1'b0;
		#SETUP_NS;
	endtask
	task automatic toggle_scl();
		scl_low = !scl_low;
		#(2 * HALF_NS);
	endtask
endmodule

// [dv/test_ustw_top.sv]
// Purpose: self-checking bench of the two-wire serial unit
// Assumes: pull-ups on both lines, master model on the far side
// Notes: each scenario task judges its own results
module test_ustw_top;
	import ustw_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [ADDR_W-1:0] s_axi_awaddr = '0;
	logic [ADDR_W-1:0] s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic timer_match = 1'b0, global_int_enable = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic scl_out, scl_oe, sda_out, sda_oe, data_out_pin, start_irq, ovf_irq;
	logic scl_pull, sda_pull, stuck, scl_line, sda_line;
	int mismatches = 0;
	int comparisons = 0;
	assign scl_line = !(scl_pull || (scl_oe && !scl_out));
	assign sda_line = !(sda_pull || (sda_oe && !sda_out));
	always #2.5 aclk = ~aclk;
	ustw_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .scl_in(scl_line),
		.scl_out, .scl_oe, .sda_in(sda_line), .sda_out, .sda_oe, .data_out_pin,
		.timer_match, .global_int_enable, .start_irq, .ovf_irq);
	ustw_master_model master (.scl_line, .scl_low(scl_pull), .sda_low(sda_pull), .stuck);
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic timed_out(input string what);
		mismatches++;
		$display("ERROR %s expected answer seen timeout", what);
		test_done();
	endtask
	task automatic axi_write(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		n = 0;
		do begin @(posedge aclk); n++; end while (!s_axi_awready && n < 50);
		if (!s_axi_awready) timed_out("write accept");
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		while (!s_axi_bvalid && n < 100) begin @(posedge aclk); n++; end
		if (!s_axi_bvalid) timed_out("write response");
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	// rready comes a cycle late so the held answer is exercised
	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		n = 0;
		do begin @(posedge aclk); n++; end while (!s_axi_arready && n < 50);
		if (!s_axi_arready) timed_out("read accept");
		s_axi_arvalid <= 1'b0;
		while (!s_axi_rvalid && n < 100) begin @(posedge aclk); n++; end
		if (!s_axi_rvalid) timed_out("read answer");
		s_axi_rready <= 1'b1;
		@(posedge aclk);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [1:0] r;
		axi_write(a, d, r);
		check("write response", {30'h0, RESP_OKAY}, {30'h0, r});
	endtask
	task automatic rd(input string what, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [31:0] v;
		logic [1:0] r;
		axi_read(a, v, r);
		check(what, {24'h0, e}, v & {24'h0, m});
	endtask
	task automatic wait_scl_oe(input logic lvl);
		int n;
		for (n = 0; n < 40 && scl_oe !== lvl; n++) @(posedge aclk);
		check("scl hold", {31'h0, lvl}, {31'h0, scl_oe});
		if (scl_oe !== lvl) test_done();
	endtask
	task automatic test_reset_map();
		logic [1:0] r;
		logic [31:0] v;
		logic [7:0] addrs [5] = '{ADDR_SHIFT, ADDR_RXBUF, ADDR_STATUS, ADDR_CTRL, ADDR_PINS};
		foreach (addrs[i]) rd("reset value", addrs[i], 8'hff, 8'h00);
		axi_read(8'h20, v, r);
		check("unmapped read", {30'h0, RESP_SLVERR}, {30'h0, r});
		axi_write(8'h20, 8'h5a, r);
		check("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, r});
		wr(ADDR_SHIFT, 8'h5a);
		rd("shift data", ADDR_SHIFT, 8'hff, 8'h5a);
		wr(ADDR_RXBUF, 8'h77);
		rd("receive buffer read only", ADDR_RXBUF, 8'hff, 8'h00);
	endtask
	// control first: pins written in no wire mode would drive scl
	task automatic test_two_wire_receive();
		wr(ADDR_CTRL, 8'h38);
		wr(ADDR_PINS, 8'h0b);
		master.start_cond();
		rd("start flag", ADDR_STATUS, 8'he0, 8'h80);
		wait_scl_oe(1'b1);
		wr(ADDR_STATUS, 8'h80);
		wait_scl_oe(1'b0);
		master.send_byte(8'ha5);
		repeat (8) @(posedge aclk);
		rd("overflow after byte", ADDR_STATUS, 8'hef, 8'h40);
		check("overflow scl hold", 32'h1, {31'h0, scl_oe});
		rd("received byte", ADDR_RXBUF, 8'hff, 8'ha5);
		rd("shifted byte", ADDR_SHIFT, 8'hff, 8'ha5);
		wr(ADDR_STATUS, 8'h40);
		wait_scl_oe(1'b0);
		master.stop_cond();
		repeat (8) @(posedge aclk);
		rd("stop flag", ADDR_STATUS, 8'he0, 8'h20);
		check("master not stalled", 32'h0, {31'h0, stuck});
	endtask
	task automatic test_soft_strobe();
		wr(ADDR_SHIFT, 8'h81);
		wr(ADDR_STATUS, 8'h0f);
		global_int_enable <= 1'b1;
		wr(ADDR_CTRL, 8'h42);
		rd("counter wrap", ADDR_STATUS, 8'h4f, 8'h40);
		rd("strobe shift", ADDR_SHIFT, 8'hff, 8'h03);
		rd("wrap copy", ADDR_RXBUF, 8'hff, 8'h03);
		check("overflow irq", 32'h1, {31'h0, ovf_irq});
		global_int_enable <= 1'b0;
		repeat (3) @(posedge aclk);
		check("overflow irq gated", 32'h0, {31'h0, ovf_irq});
	endtask
	task automatic test_timer_count();
		wr(ADDR_CTRL, 8'h14);
		wr(ADDR_STATUS, 8'h40);
		repeat (3) begin
			@(posedge aclk);
			timer_match <= 1'b1;
			@(posedge aclk);
			timer_match <= 1'b0;
		end
		rd("timer count", ADDR_STATUS, 8'h0f, 8'h03);
		rd("timer shift", ADDR_SHIFT, 8'hff, 8'h1f);
		wr(ADDR_SHIFT, 8'h80);
		repeat (2) @(posedge aclk);
		check("serial output high", 32'h1, {31'h0, data_out_pin});
		timer_match <= 1'b1;
		@(posedge aclk);
		timer_match <= 1'b0;
		repeat (2) @(posedge aclk);
		check("serial output follows", 32'h0, {31'h0, data_out_pin});
	endtask
	// pins released first so the master never fights a driven scl
	task automatic test_edge_start();
		wr(ADDR_PINS, 8'h00);
		wr(ADDR_CTRL, 8'h08);
		wr(ADDR_STATUS, 8'h80);
		master.toggle_scl();
		rd("edge start", ADDR_STATUS, 8'h8f, 8'h81);
		master.toggle_scl();
		rd("both edges", ADDR_STATUS, 8'h0f, 8'h02);
		wr(ADDR_STATUS, 8'h4e);
		master.toggle_scl();
		master.toggle_scl();
		rd("ack bit overflow", ADDR_STATUS, 8'h4f, 8'h40);
		wr(ADDR_STATUS, 8'h80);
		rd("start cleared", ADDR_STATUS, 8'h80, 8'h00);
	endtask
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		test_reset_map();
		test_two_wire_receive();
		test_soft_strobe();
		test_timer_count();
		test_edge_start();
		test_done();
	end
endmodule
